// [verilog/cbg_pkg.sv]
// constants shared by the byte-wise crc generator
package cbg_pkg;
  // ------------------------------------------------------------------
  // polynomial selection
  // ------------------------------------------------------------------
  localparam logic        POLYNOMIAL_SELECT_SEL_CCITT  = 1'b0;
  localparam logic        POLYNOMIAL_SELECT_SEL_CRC16  = 1'b1;
  localparam logic [15:0] POLYNOMIAL_SELECT_CCITT      = 16'h1021;
  localparam logic [15:0] POLYNOMIAL_SELECT_CRC16      = 16'h8005;
  // ------------------------------------------------------------------
  // widths, field positions, reset values
  // ------------------------------------------------------------------
  localparam int          BYTE_W          = 8;
  localparam int          SUM_W           = 16;
  localparam int          POLYNOMIAL_SELECT_BIT        = 0;
  localparam logic [7:0]  INPUT_RST       = 8'h00;
  localparam logic [15:0] SUM_RST         = 16'h0000;
  localparam logic        POLYNOMIAL_SELECT_RST        = 1'b0;
  localparam logic [6:0]  CTRL_UNUSED_VAL = 7'h00;
  // one byte is folded in per clock: the update takes a single cycle
  localparam int          UPDATE_CYCLES   = 1;
endpackage

// [verilog/cbg_step_if.sv]
// carrier between the generator top and its byte-step datapath
`timescale 1ns/1ps
`default_nettype none
interface cbg_step_if;
  logic [15:0] sum_in;    // checksum before the byte
  logic [7:0]  data_in;   // byte to fold in
  logic        polynomial_select_sel;  // 0 ccitt, 1 crc-16
  logic [15:0] sum_out;   // checksum after the byte

  modport calc (input sum_in, input data_in, input polynomial_select_sel, output sum_out);
  modport user (output sum_in, output data_in, output polynomial_select_sel, input sum_out);
endinterface
`default_nettype wire

// [verilog/cbg_byte_step.sv]
// eight shift-and-conditional-xor stages folding one byte into the checksum
`timescale 1ns/1ps
`default_nettype none
module cbg_byte_step
  import cbg_pkg::*;
(
  cbg_step_if.calc step  // operands in, next checksum out
);
  // ------------------------------------------------------------------
  // unrolled bit stages
  // ------------------------------------------------------------------
  logic [15:0] polynomial_select_val;
  logic [15:0] stage [0:BYTE_W];

  // only the two fixed polynomials exist
  assign polynomial_select_val = (step.polynomial_select_sel == POLYNOMIAL_SELECT_SEL_CRC16) ? POLYNOMIAL_SELECT_CRC16 : POLYNOMIAL_SELECT_CCITT;

  // byte enters at the high half
  assign stage[0] = step.sum_in ^ {step.data_in, 8'h00};

  // one stage per input bit; the tested bit is the one shifted out
  for (genvar i = 0; i < BYTE_W; i++) begin : g_bit
    assign stage[i+1] = stage[i][15] ? ({stage[i][14:0], 1'b0} ^ polynomial_select_val)
                                     : {stage[i][14:0], 1'b0};
  end

  assign step.sum_out = stage[BYTE_W];
endmodule
`default_nettype wire

// [verilog/cbg_top.sv]
// byte-wise crc-16 / crc-ccitt checksum generator with plain register ports
`timescale 1ns/1ps
`default_nettype none
module cbg_top
  import cbg_pkg::*;
(
  input  wire logic       MCLK,                     // 100 MHz clock
  input  wire logic       RST_B,                    // async reset, active low
  input  wire logic       INPUT_WR,                 // write strobe, input byte
  input  wire logic       HIGH_WR,                  // write strobe, checksum high byte
  input  wire logic       LOW_WR,                   // write strobe, checksum low byte
  input  wire logic       CONTROL_WR,               // write strobe, control byte
  input  wire logic [7:0] WRITE_DATA,               // data for any write strobe
  output logic      [7:0] CHECKSUM_INPUT_BYTE,      // input byte readback
  output logic      [7:0] CHECKSUM_HIGH_BYTE,       // running checksum bits 15..8
  output logic      [7:0] CHECKSUM_LOW_BYTE,        // running checksum bits 7..0
  output logic      [7:0] CHECKSUM_CONTROL,         // control readback
  output logic            POLYNOMIAL_SELECT         // current polynomial select
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [15:0] running_checksum_reg;
  logic [15:0] running_checksum_next;
  logic [7:0]  input_byte_reg;
  logic        polynomial_select_reg;
  logic        direct_wr;

  cbg_step_if step_bus ();

  cbg_byte_step u_step (
    .step (step_bus.calc)
  );

  assign step_bus.sum_in   = running_checksum_reg;
  assign step_bus.data_in  = WRITE_DATA;
  assign step_bus.polynomial_select_sel = polynomial_select_reg;

  // ------------------------------------------------------------------
  // polynomial select
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      polynomial_select_reg <= POLYNOMIAL_SELECT_RST;
    end else if (CONTROL_WR) begin
      polynomial_select_reg <= WRITE_DATA[POLYNOMIAL_SELECT_BIT];
    end
  end

  // ------------------------------------------------------------------
  // input byte register
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      input_byte_reg <= INPUT_RST;
    end else if (INPUT_WR) begin
      input_byte_reg <= WRITE_DATA;
    end
  end

  // ------------------------------------------------------------------
  // running checksum
  // ------------------------------------------------------------------
  // a direct byte write suppresses the fold so a clear cannot be spoilt
  assign direct_wr = HIGH_WR | LOW_WR;

  always_comb begin
    running_checksum_next = running_checksum_reg;
    if (direct_wr) begin
      if (HIGH_WR) begin
        running_checksum_next[15:8] = WRITE_DATA;
      end
      if (LOW_WR) begin
        running_checksum_next[7:0] = WRITE_DATA;
      end
    end else if (INPUT_WR) begin
      running_checksum_next = step_bus.sum_out;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      running_checksum_reg <= SUM_RST;
    end else begin
      running_checksum_reg <= running_checksum_next;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign CHECKSUM_INPUT_BYTE = input_byte_reg;
  assign CHECKSUM_HIGH_BYTE  = running_checksum_reg[15:8];
  assign CHECKSUM_LOW_BYTE   = running_checksum_reg[7:0];
  assign CHECKSUM_CONTROL    = {CTRL_UNUSED_VAL, polynomial_select_reg};
  assign POLYNOMIAL_SELECT   = polynomial_select_reg;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  // independent bit-serial model, read only by the checks below
  function automatic logic [15:0] ref_crc(input logic [15:0] sum,
                                          input logic [7:0]  data,
                                          input logic        sel);
    logic [15:0] t;
    logic [15:0] p;
    logic        top;
    t = sum ^ {data, 8'h00};
    p = sel ? POLYNOMIAL_SELECT_CRC16 : POLYNOMIAL_SELECT_CCITT;
    for (int k = 0; k < 8; k++) begin
      top = t[15];
      t   = {t[14:0], 1'b0};
      if (top) begin
        t = t ^ p;
      end
    end
    return t;
  endfunction

  logic fold_now;
  assign fold_now = INPUT_WR & ~direct_wr;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_B);

  fold_update_a: assert property (fold_now |=>
    {CHECKSUM_HIGH_BYTE, CHECKSUM_LOW_BYTE} ==
      ref_crc($past(running_checksum_reg), $past(WRITE_DATA), $past(polynomial_select_reg)))
    else $error("checksum fold result wrong");

  sum_hold_a: assert property (!INPUT_WR && !direct_wr |=>
    $stable({CHECKSUM_HIGH_BYTE, CHECKSUM_LOW_BYTE}))
    else $error("checksum changed without a write");

  ccitt_vec_a: assert property (fold_now && running_checksum_reg == 16'h0000 &&
    !polynomial_select_reg && WRITE_DATA == 8'h01 |=> {CHECKSUM_HIGH_BYTE, CHECKSUM_LOW_BYTE} == 16'h1021)
    else $error("ccitt single byte vector wrong");

  crc16_vec_a: assert property (fold_now && running_checksum_reg == 16'h0000 &&
    polynomial_select_reg && WRITE_DATA == 8'h02 |=> {CHECKSUM_HIGH_BYTE, CHECKSUM_LOW_BYTE} == 16'h800F)
    else $error("crc16 single byte vector wrong");

  top_bit_a: assert property (fold_now && running_checksum_reg == 16'h0000 &&
    polynomial_select_reg && WRITE_DATA == 8'h03 |=> {CHECKSUM_HIGH_BYTE, CHECKSUM_LOW_BYTE} == 16'h000A)
    else $error("tested bit is not the shifted out bit");

  zero_byte_a: assert property (fold_now && running_checksum_reg == 16'h0000 &&
    WRITE_DATA == 8'h00 |=> {CHECKSUM_HIGH_BYTE, CHECKSUM_LOW_BYTE} == 16'h0000)
    else $error("zero byte must leave zero checksum");

  lsb_zero_a: assert property (fold_now && running_checksum_reg == 16'h0000 &&
    !polynomial_select_reg && WRITE_DATA == 8'h04 |=> CHECKSUM_LOW_BYTE == 8'h84)
    else $error("shift does not insert zero");

  polynomial_select_write_a: assert property (CONTROL_WR |=>
    POLYNOMIAL_SELECT == $past(WRITE_DATA[POLYNOMIAL_SELECT_BIT]) && CHECKSUM_CONTROL[7:1] == 7'h00)
    else $error("polynomial select write wrong");

  polynomial_select_hold_a: assert property (!CONTROL_WR |=> $stable(POLYNOMIAL_SELECT))
    else $error("polynomial select changed unwritten");

  byte_write_a: assert property (HIGH_WR && !LOW_WR |=>
    CHECKSUM_HIGH_BYTE == $past(WRITE_DATA) && $stable(CHECKSUM_LOW_BYTE))
    else $error("high byte write wrong");

  ccitt_fold_c: cover property (fold_now && !polynomial_select_reg);
  crc16_fold_c: cover property (fold_now && polynomial_select_reg);
  back_to_back_c: cover property (fold_now ##1 fold_now ##1 fold_now);
  clear_then_fold_c: cover property ((HIGH_WR && LOW_WR) ##1 fold_now);
endmodule
`default_nettype wire

// [test/test_crc16_byte_generator.sv]
// self-checking bench for the byte-wise crc generator
`timescale 1ns/1ps
`default_nettype none
module test_crc16_byte_generator;
  import cbg_pkg::*;
  logic       mclk;
  logic       rst_b;
  logic       in_wr;
  logic       hi_wr;
  logic       lo_wr;
  logic       ctl_wr;
  logic [7:0] wdata;
  logic [7:0] in_byte;
  logic [7:0] hi_byte;
  logic [7:0] lo_byte;
  logic [7:0] ctl_byte;
  logic       polynomial_select;
  int         err_total;
  int         total_checks;
  int         cycles;
  logic [15:0] exp_sum;
  // ------------------------------------------------------------------
  // expected values: single bytes from zero, then a four-byte chain per polynomial
  // ------------------------------------------------------------------
  localparam logic [15:0] SINGLE [16] = '{16'h0000, 16'h1021, 16'h2042, 16'h3063,
    16'h4084, 16'h50A5, 16'h60C6, 16'h70E7, 16'h0000, 16'h8005, 16'h800F, 16'h000A,
    16'h801B, 16'h001E, 16'h0014, 16'h8011};
  localparam logic [7:0]  SEQD [4]   = '{8'h78, 8'h56, 8'h34, 8'h12};
  localparam logic [15:0] SEQ [8]    = '{16'hFF9F, 16'hBBC3, 16'hA367, 16'hD0FA,
    16'h0110, 16'h91F1, 16'hF2DE, 16'h5C43};

  cbg_top dut_u (
    .MCLK                (mclk),
    .RST_B               (rst_b),
    .INPUT_WR            (in_wr),
    .HIGH_WR             (hi_wr),
    .LOW_WR              (lo_wr),
    .CONTROL_WR          (ctl_wr),
    .WRITE_DATA          (wdata),
    .CHECKSUM_INPUT_BYTE (in_byte),
    .CHECKSUM_HIGH_BYTE  (hi_byte),
    .CHECKSUM_LOW_BYTE   (lo_byte),
    .CHECKSUM_CONTROL    (ctl_byte),
    .POLYNOMIAL_SELECT   (polynomial_select)
  );

  // bit-serial reference, kept apart from the design's own step logic
  function automatic logic [15:0] ref_fold(input logic [15:0] s, input logic [7:0] d,
                                           input logic p);
    logic [15:0] t;
    t = s ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) t = t[15] ? ((t << 1) ^ (p ? POLYNOMIAL_SELECT_CRC16 : POLYNOMIAL_SELECT_CCITT)) : (t << 1);
    return t;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // strobes {input, high, low, control}; held across one clock edge, never pulsed twice in a step
  task automatic wr(input logic [3:0] st, input logic [7:0] d);
    {in_wr, hi_wr, lo_wr, ctl_wr} = st;
    wdata = d;
    @(posedge mclk);
    #1;
  endtask

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    rst_b = 1'b0;
    {in_wr, hi_wr, lo_wr, ctl_wr} = 4'h0;
    wdata = 8'h00;
    repeat (10) @(posedge mclk);
    #1 rst_b = 1'b1;
    chk({in_byte, hi_byte, lo_byte, ctl_byte}, 32'h0);
    // ------------------------------------------------------------------
    // table rows: clear, select, one byte from zero
    // ------------------------------------------------------------------
    for (int r = 0; r < 16; r++) begin
      wr(4'b0110, 8'h00);
      wr(4'b0001, 8'(r / 8));
      chk({ctl_byte, 7'h00, polynomial_select}, 16'(r / 8) * 16'h0101);
      wr(4'b1000, 8'(r % 8));
      chk({hi_byte, lo_byte}, SINGLE[r]);
    end
    // back-to-back folds, one per cycle, chained from the previous result
    for (int p = 0; p < 2; p++) begin
      wr(4'b0110, 8'h00);
      wr(4'b0001, 8'(p));
      for (int k = 0; k < 4; k++) begin
        wr(4'b1000, SEQD[k]);
        chk({in_byte, hi_byte, lo_byte}, {SEQD[k], SEQ[p * 4 + k]});
      end
    end
    // only bit 0 of control is stored; upper bits read zero
    wr(4'b0001, 8'hFE);
    chk({ctl_byte, 7'h00, polynomial_select}, 16'h0000);
    // direct byte writes beat a simultaneous fold
    wr(4'b1110, 8'h3C);
    chk({in_byte, hi_byte, lo_byte}, 24'h3C3C3C);
    wr(4'b1000, 8'hC3);
    chk({hi_byte, lo_byte}, ref_fold(16'h3C3C, 8'hC3, 1'b0));
    // a high byte write with a control write replaces bits 15..8, keeps the low byte of the fold and selects crc-16
    exp_sum = ref_fold(16'h3C3C, 8'hC3, 1'b0);
    wr(4'b0101, 8'h81);
    exp_sum[15:8] = 8'h81;
    chk({hi_byte, lo_byte}, exp_sum);
    chk({ctl_byte, 7'h00, polynomial_select}, 16'h0101);
    wr(4'b1000, 8'h5A);
    exp_sum = ref_fold(exp_sum, 8'h5A, 1'b1);
    chk({hi_byte, lo_byte}, exp_sum);
    // idle cycles leave the running value alone
    wr(4'b0000, 8'h77);
    repeat (3) @(posedge mclk);
    #1;
    chk({hi_byte, lo_byte}, exp_sum);
    // reset in mid-run acts without a clock edge
    rst_b = 1'b0;
    #2;
    chk({in_byte, hi_byte, lo_byte, ctl_byte}, 32'h0);
    @(posedge mclk);
    #1 rst_b = 1'b1;
    wr(4'b1000, 8'h01);
    chk({hi_byte, lo_byte}, 16'h1021);
    give_verdict();
  end
endmodule
`default_nettype wire
